// [rtl/io_output_ack_timebase.sv]
// output character selection, peripheral acknowledges and time-base interrupt
// Contract
// R1: count zero eight-bit sends bits 16-23
// R2: final count eight-bit sends bits 0-7
// R3: after last char update control word
// R4: external function forces final count, sends instruction
// R5: six-bit first 18-23, last 0-5
// R6: middle characters in descending bit order
// R7: honoured input request raises input acknowledge
// R8: honoured output request raises output acknowledge
// R9: acknowledge cleared 1.2, set 1.3
// R10: acknowledge gated from 6.3 to next 6.3
// R11: flip-flops cleared at next 1.2
// R12: external function read sends acknowledge too
// R13: one flip-flop per acknowledge line
// R14: tape acknowledges on requests and unit code
// R15: console acknowledge with output or alone
// R16: paper tape acknowledges each honoured request
// R17: aux input acknowledge on request or code
// R18: aux output acknowledge on request or code
// R19: punch acknowledge on request or code
// R20: software sets jump and tally word
// R21: tally sets interrupt length in ticks
// R22: subroutine returns through the return word
// R23: interrupt uses three control sequences
// R24: zero tally disarms, saves and loads counter
// R25: armed logic requests at one kilohertz
// R26: character register loaded at step 3.3
// R27: six-bit characters carry odd parity
`timescale 1ns/1ps
`default_nettype none

module char_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst_b,
    // fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    logic             doPush;
    logic             doPop;

    // honest flags from the occupancy count
    assign inReady  = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;

    // pointers and count
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doPush) wrPtr <= wrPtr + 1'b1;
            if (doPop) rdPtr <= rdPtr + 1'b1;
            count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end

    // storage has no reset; only read behind valid
    always_ff @(posedge clock) begin
        if (doPush) mem[wrPtr] <= inData;
    end
endmodule

module io_output_ack_timebase
#(
    parameter int TICK_COUNT = io_ack_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic                            clock,
    input  wire logic                            rst_b,
    // sequencer and honoured request
    input  wire io_ack_pkg::seq_t                seq,
    input  wire io_ack_pkg::honor_t              honor,
    input  wire io_ack_pkg::ctrl_word_t          ctrlWord,
    input  wire logic [23:0]                     memWord,
    input  wire logic [23:0]                     exfInstr,
    input  wire logic [4:0]                      exfUnit,
    // control word write-back
    output io_ack_pkg::ctrl_word_t               nextCtrlWord,
    output logic                                 ctrlWordWrite,
    // output characters toward peripherals
    output logic                                 charValid,
    input  wire logic                            charReady,
    output io_ack_pkg::char_t                    charData,
    output logic                                 charSpace,
    // acknowledge lines
    output logic [io_ack_pkg::ACK_N-1:0]         ackLines,
    // time-base interrupt
    input  wire logic                            armSet,
    input  wire logic                            armClear,
    input  wire logic                            intHonored,
    input  wire logic [23:0]                     intWord,
    input  wire logic [13:0]                     progCount,
    output logic                                 armed,
    output logic                                 intRequest,
    output logic [13:0]                          returnAddr,
    output logic [13:0]                          newProgCount,
    output logic                                 loadProg,
    output logic [io_ack_pkg::TALLY_W-1:0]       tallyNext,
    output logic                                 tallyWrite
);
    import io_ack_pkg::*;

    typedef struct packed {
        logic [ACK_N-1:0]   ackFf;
        logic [ACK_N-1:0]   ackLine;
        logic               pushValid;
        char_t              pushChar;
        ctrl_word_t         cw;
        logic               cwWr;
        logic               armed;
        logic               intReq;
        logic [TICK_W-1:0]  tick;
        logic [13:0]        retAddr;
        logic [13:0]        newP;
        logic               loadP;
        logic [TALLY_W-1:0] tally;
        logic               tallyWr;
    } state_t;

    state_t st;
    state_t next_st;
    logic   pushReady;

    // acknowledge line for a honoured request; each console has one line for both directions
    function automatic int ackIndex(input periph_t unit, input logic isInput);
        unique case (unit)
            PER_TAPE:  ackIndex = isInput ? ACK_TAPE_IN : ACK_TAPE_OUT;
            PER_PAPER: ackIndex = isInput ? ACK_PAPER_IN : ACK_PAPER_OUT;
            PER_PUNCH: ackIndex = ACK_PUNCH_OUT;
            PER_AUX:   ackIndex = isInput ? ACK_AUX_IN : ACK_AUX_OUT;
            default:   ackIndex = ACK_CONS_BASE + int'(unit) - int'(PER_CONS0);
        endcase
    endfunction

    // character picked from the word by count and mode
    function automatic logic [7:0] pickChar(input logic [23:0] w, input logic [1:0] cc,
                                            input logic six);
        logic [5:0] c6;
        c6 = 6'h00;
        if (six) begin
            unique case (cc)
                2'h0: c6 = w[23:18]; // [R5]
                2'h1: c6 = w[17:12]; // [R6]
                2'h2: c6 = w[11:6];  // [R6]
                2'h3: c6 = w[5:0];   // [R5]
            endcase
            pickChar = {1'b0, ~^c6, c6}; // odd parity beside the six data bits [R27]
        end else begin
            unique case (cc)
                2'h0:    pickChar = w[23:16]; // [R1]
                2'h1:    pickChar = w[15:8];  // [R6]
                default: pickChar = w[7:0];   // [R2]
            endcase
        end
    endfunction

    // next state
    always_comb begin
        logic        outReq;
        logic        last;
        next_st = st;
        outReq = honor.valid && !honor.isInput;
        last = honor.sixBit ? (ctrlWord.charCount == CC_LAST6)
                            : (ctrlWord.charCount == CC_LAST8);
        next_st.pushValid = 1'b0;
        next_st.cwWr = 1'b0;
        next_st.loadP = 1'b0;
        next_st.tallyWr = 1'b0;

        // acknowledge flip-flops, one per line [R13]
        if (seq.step == STEP_1_2 && (seq.kind == SEQ_RW || seq.kind == SEQ_EXF_READ)) begin
            next_st.ackFf = '0; // [R9] [R11]
        end
        if (seq.step == STEP_1_3 && seq.kind == SEQ_RW && honor.valid) begin
            next_st.ackFf[ackIndex(honor.unit, honor.isInput)] = 1'b1; // [R7] [R8] [R9] [R15] [R16]
        end
        if (seq.step == STEP_1_3 && seq.kind == SEQ_EXF_READ) begin
            // unit codes pick the line for an external function [R12]
            unique case (exfUnit)
                UNIT_TAPE:    next_st.ackFf[ACK_TAPE_OUT] = 1'b1; // [R14]
                UNIT_AUX_IN:  next_st.ackFf[ACK_AUX_IN] = 1'b1;   // [R17]
                UNIT_AUX_OUT: next_st.ackFf[ACK_AUX_OUT] = 1'b1;  // [R18]
                UNIT_PUNCH:   next_st.ackFf[ACK_PUNCH_OUT] = 1'b1; // [R19]
                default:      ;
            endcase
        end
        // peripheral sees the flip-flops only from 6.3 to the next 6.3
        if (seq.step == STEP_6_3) begin
            next_st.ackLine = (seq.kind == SEQ_RW || seq.kind == SEQ_EXF_READ)
                              ? st.ackFf : '0; // [R10]
        end

        // character register load and control word update at 3.3
        if (seq.step == STEP_3_3 && seq.kind == SEQ_RW && outReq) begin
            next_st.pushValid = 1'b1; // [R26]
            next_st.pushChar.unit = honor.unit;
            next_st.pushChar.data = pickChar(memWord, ctrlWord.charCount, honor.sixBit);
            next_st.cwWr = 1'b1;
            next_st.cw = ctrlWord;
            if (last) begin
                next_st.cw.charCount = CC_FIRST; // [R3]
                next_st.cw.wordCount = ctrlWord.wordCount - 8'h01;
                next_st.cw.address = ctrlWord.address + 14'h0001;
            end else begin
                next_st.cw.charCount = ctrlWord.charCount + 2'h1;
            end
        end
        if (seq.step == STEP_3_3 && seq.kind == SEQ_EXF_READ) begin
            next_st.pushValid = 1'b1; // [R4] [R26]
            next_st.pushChar.unit = honor.unit;
            next_st.pushChar.data = pickChar(exfInstr, CC_LAST8, 1'b0); // final count [R4]
        end

        if (seq.step == STEP_1_3 && intHonored) begin
            next_st.intReq = 1'b0; // taken by priority; a tick in this cycle still sets it
        end
        // time base: free tick while armed [R25]
        if (armSet) begin
            next_st.armed = 1'b1;
            next_st.tick = '0;
        end else if (st.armed) begin
            if (st.tick == TICK_W'(TICK_COUNT - 1)) begin
                next_st.tick = '0;
                next_st.intReq = 1'b1;
            end else begin
                next_st.tick = st.tick + 1'b1;
            end
        end
        // interrupt read sequence with zero tally [R23] [R24]
        if (seq.kind == SEQ_INT_READ && intWord[TALLY_LSB +: TALLY_W] == '0) begin
            if (seq.step == STEP_1_2) begin
                next_st.armed = 1'b0; // [R24]
                next_st.intReq = 1'b0;
            end
            if (seq.step == STEP_1_3) begin
                next_st.retAddr = progCount; // [R24]
                next_st.newP = intWord[JUMP_W-1:0];
                next_st.loadP = 1'b1;
            end
        end
        // control word write at 3.3 counts the tally down when intHonored is set [R21] [R23]
        if (seq.kind == SEQ_CW_WRITE && seq.step == STEP_3_3 && intHonored) begin
            next_st.tally = intWord[TALLY_LSB +: TALLY_W] - 10'h001; // [R21]
            next_st.tallyWr = 1'b1;
        end
        if (armClear) begin
            next_st.armed = 1'b0; // disarm wins over arm
            next_st.intReq = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) st <= '0;
        else st <= next_st;
    end

    // output buffer; a full buffer drops a push, so charSpace gates the sequencer
    char_fifo #(.WIDTH(CHAR_W), .DEPTH(FIFO_DEPTH)) char_fifo_i (
        .clock    (clock),
        .rst_b    (rst_b),
        .inValid  (st.pushValid),
        .inReady  (pushReady),
        .inData   (st.pushChar),
        .outValid (charValid),
        .outReady (charReady),
        .outData  (charData)
    );

    assign charSpace     = pushReady;
    assign ackLines      = st.ackLine;
    assign nextCtrlWord  = st.cw;
    assign ctrlWordWrite = st.cwWr;
    assign armed         = st.armed;
    assign intRequest    = st.intReq;
    assign returnAddr    = st.retAddr;
    assign newProgCount  = st.newP;
    assign loadProg      = st.loadP;
    assign tallyNext     = st.tally;
    assign tallyWrite    = st.tallyWr;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence s_out33;
        seq.step == STEP_3_3 && seq.kind == SEQ_RW && honor.valid && !honor.isInput;
    endsequence

    property p_first8;
        s_out33 and (!honor.sixBit && ctrlWord.charCount == CC_FIRST) |=>
            st.pushChar.data == $past(memWord[23:16]);
    endproperty
    a_first8: assert property (p_first8) else $error("first 8-bit char wrong"); // [R1]

    property p_last8;
        s_out33 and (!honor.sixBit && ctrlWord.charCount == CC_LAST8) |=>
            st.pushChar.data == $past(memWord[7:0]) && nextCtrlWord.charCount == CC_FIRST;
    endproperty
    a_last8: assert property (p_last8) else $error("last 8-bit char wrong"); // [R2]

    property p_update;
        s_out33 and (!honor.sixBit && ctrlWord.charCount == CC_LAST8) |=>
            ctrlWordWrite && nextCtrlWord.address == $past(ctrlWord.address) + 14'h0001
            && nextCtrlWord.wordCount == $past(ctrlWord.wordCount) - 8'h01;
    endproperty
    a_update: assert property (p_update) else $error("control word not updated"); // [R3]

    property p_exf;
        seq.step == STEP_3_3 && seq.kind == SEQ_EXF_READ |=>
            st.pushValid && st.pushChar.data == $past(exfInstr[7:0]);
    endproperty
    a_exf: assert property (p_exf) else $error("external function char wrong"); // [R4]

    property p_six_first;
        s_out33 and (honor.sixBit && ctrlWord.charCount == CC_FIRST) |=>
            st.pushChar.data[5:0] == $past(memWord[23:18]) && ^st.pushChar.data[6:0];
    endproperty
    a_six_first: assert property (p_six_first) else $error("six-bit first char wrong"); // [R5]

    property p_ack_clear;
        seq.step == STEP_1_2 && seq.kind == SEQ_RW |=> st.ackFf == '0;
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("ack flops not cleared"); // [R11]

    property p_ack_set;
        seq.step == STEP_1_3 && seq.kind == SEQ_RW && honor.valid |=>
            st.ackFf[ackIndex($past(honor.unit), $past(honor.isInput))];
    endproperty
    a_ack_set: assert property (p_ack_set) else $error("ack flop not set"); // [R9]

    property p_gate;
        seq.step != STEP_6_3 |=> $stable(ackLines);
    endproperty
    a_gate: assert property (p_gate) else $error("ack line moved off step 6.3"); // [R10]

    property p_disarm;
        seq.kind == SEQ_INT_READ && seq.step == STEP_1_2 && !armSet
            && intWord[TALLY_LSB +: TALLY_W] == '0 |=> !armed;
    endproperty
    a_disarm: assert property (p_disarm) else $error("zero tally did not disarm"); // [R24]

    property p_no_req_unarmed;
        !armed && !armSet |=> !$rose(intRequest);
    endproperty
    a_no_req_unarmed: assert property (p_no_req_unarmed) else $error("request while unarmed"); // [R25]
endmodule

`default_nettype wire

// [rtl/io_ack_pkg.sv]
// shared types and constants for the output character and acknowledge block
package io_ack_pkg;
    // sequencer timing
    typedef enum logic [2:0] {SEQ_IDLE, SEQ_RW, SEQ_EXF_READ, SEQ_CW_READ, SEQ_INT_READ,
                              SEQ_CW_WRITE} seq_kind_t;
    typedef enum logic [2:0] {STEP_NONE, STEP_1_2, STEP_1_3, STEP_3_3, STEP_6_3} seq_step_t;
    typedef struct packed {
        seq_kind_t kind;
        seq_step_t step;
    } seq_t;
    // peripherals
    typedef enum logic [2:0] {PER_TAPE, PER_CONS0, PER_CONS1, PER_CONS2, PER_CONS3,
                              PER_PAPER, PER_PUNCH, PER_AUX} periph_t;
    typedef struct packed {
        logic    valid;
        periph_t unit;
        logic    isInput;
        logic    sixBit;
    } honor_t;
    typedef struct packed {
        logic [1:0]  charCount;
        logic [7:0]  wordCount;
        logic [13:0] address;
    } ctrl_word_t;
    typedef struct packed {
        periph_t    unit;
        logic [7:0] data;
    } char_t;
    // acknowledge line indices
    localparam int ACK_N         = 11;
    localparam int ACK_TAPE_OUT  = 0;
    localparam int ACK_TAPE_IN   = 1;
    localparam int ACK_CONS_BASE = 2;
    localparam int ACK_PAPER_IN  = 6;
    localparam int ACK_PAPER_OUT = 7;
    localparam int ACK_PUNCH_OUT = 8;
    localparam int ACK_AUX_IN    = 9;
    localparam int ACK_AUX_OUT   = 10;
    // character counts
    localparam logic [1:0] CC_FIRST = 2'h0;
    localparam logic [1:0] CC_LAST8 = 2'h2;
    localparam logic [1:0] CC_LAST6 = 2'h3;
    // external function unit codes
    localparam logic [4:0] UNIT_TAPE    = 5'h01;
    localparam logic [4:0] UNIT_AUX_IN  = 5'h06;
    localparam logic [4:0] UNIT_AUX_OUT = 5'h04;
    localparam logic [4:0] UNIT_PUNCH   = 5'h03;
    // interrupt control word fields
    localparam int TALLY_LSB = 14;
    localparam int TALLY_W   = 10;
    localparam int JUMP_W    = 14;
    // time base
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_NS  = 1_000_000;
    localparam int TICK_CYCLES     = TICK_PERIOD_NS / CLOCK_PERIOD_NS;
    localparam int TICK_W          = 17;
    // buffering
    localparam int FIFO_DEPTH = 16;
    localparam int CHAR_W     = $bits(char_t);
endpackage

// [sim/periph_model.sv]
// peripheral-side model that takes output characters from the block
`timescale 1ns/1ps
`default_nettype none
module periph_model (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst_b,
    // character stream
    input  wire logic              charValid,
    output logic                   charReady,
    input  wire io_ack_pkg::char_t charData,
    // bench control: slow peer
    input  wire logic              stall
);
    import io_ack_pkg::*;
    char_t got[$];
    // ready follows stall a cycle late, like a busy peripheral would
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            charReady <= 1'b0;
        end else begin
            charReady <= !stall;
        end
    end
    // keep every character taken so the bench can judge order and content
    always @(posedge clock) begin
        if (rst_b && charValid && charReady) begin
            got.push_back(charData);
        end
    end
endmodule
`default_nettype wire

// [sim/io_output_ack_timebase_test.sv]
// self-checking bench for the output character, acknowledge and time-base block
`timescale 1ns/1ps
`default_nettype none
module io_output_ack_timebase_test;
    import io_ack_pkg::*;
    localparam int TICKS = 8; // short tick keeps the run brief
    logic               clock, rst_b, stall;
    seq_t               seq;
    honor_t             honor;
    ctrl_word_t         ctrlWord, nextCtrlWord;
    logic [23:0]        memWord, exfInstr, intWord;
    logic [4:0]         exfUnit;
    logic               ctrlWordWrite, charValid, charReady, charSpace;
    char_t              charData;
    logic [ACK_N-1:0]   ackLines, lastAck;
    logic               armSet, armClear, intHonored, armed, intRequest, loadProg, tallyWrite;
    logic [13:0]        progCount, returnAddr, newProgCount;
    logic [TALLY_W-1:0] tallyNext;
    int                 numErrors, checkCount;
    char_t              expQ[$];

    io_output_ack_timebase #(.TICK_COUNT(TICKS)) io_output_ack_timebase_i (
        .clock(clock), .rst_b(rst_b), .seq(seq), .honor(honor), .ctrlWord(ctrlWord),
        .memWord(memWord), .exfInstr(exfInstr), .exfUnit(exfUnit),
        .nextCtrlWord(nextCtrlWord), .ctrlWordWrite(ctrlWordWrite), .charValid(charValid),
        .charReady(charReady), .charData(charData), .charSpace(charSpace),
        .ackLines(ackLines), .armSet(armSet), .armClear(armClear), .intHonored(intHonored),
        .intWord(intWord), .progCount(progCount), .armed(armed), .intRequest(intRequest),
        .returnAddr(returnAddr), .newProgCount(newProgCount), .loadProg(loadProg),
        .tallyNext(tallyNext), .tallyWrite(tallyWrite));
    periph_model periph_model_i (.clock(clock), .rst_b(rst_b), .charValid(charValid),
        .charReady(charReady), .charData(charData), .stall(stall));

    // clock at 100 MHz
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checkCount, numErrors);
        if (numErrors == 0 && checkCount > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checkCount++;
        if (seen !== exp) begin
            numErrors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one-cycle step pulse, results settled on return
    task automatic step(input seq_kind_t k, input seq_step_t s);
        @(posedge clock);
        seq <= '{k, s};
        @(posedge clock);
        seq <= '{k, STEP_NONE};
        #1;
    endtask

    function automatic logic [7:0] pick(input logic [23:0] w, input logic six,
                                        input logic [1:0] cc);
        logic [5:0] c;
        c = w[23-6*cc -: 6];
        if (six) return {1'b0, ~^c, c};
        return w[23-8*cc -: 8];
    endfunction

    function automatic int ackIdx(input periph_t u, input logic isIn);
        case (u)
            PER_TAPE:  return isIn ? ACK_TAPE_IN : ACK_TAPE_OUT;
            PER_PAPER: return isIn ? ACK_PAPER_IN : ACK_PAPER_OUT;
            PER_PUNCH: return ACK_PUNCH_OUT;
            PER_AUX:   return isIn ? ACK_AUX_IN : ACK_AUX_OUT;
            default:   return ACK_CONS_BASE + int'(u) - int'(PER_CONS0);
        endcase
    endfunction

    // one read/write sequence for an honoured request
    task automatic rw(input periph_t u, input logic isIn, input logic six,
                      input logic [1:0] cc, input logic [23:0] w);
        logic       last;
        ctrl_word_t expCw;
        last = (cc == (six ? CC_LAST6 : CC_LAST8));
        expCw = last ? ctrl_word_t'{CC_FIRST, 8'h04, 14'h0101}
                     : ctrl_word_t'{cc + 2'h1, 8'h05, 14'h0100};
        @(posedge clock);
        honor <= '{1'b1, u, isIn, six};
        ctrlWord <= '{cc, 8'h05, 14'h0100};
        memWord <= w;
        step(SEQ_RW, STEP_1_2);
        chk("ackLines held past 1.2", lastAck, ackLines);
        step(SEQ_RW, STEP_1_3);
        step(SEQ_RW, STEP_3_3);
        if (!isIn) begin
            // write strobe stands only in the cycle after step 3.3
            chk("ctrlWordWrite", 1, ctrlWordWrite);
            chk("nextCtrlWord", expCw, nextCtrlWord);
            expQ.push_back(char_t'{u, pick(w, six, cc)});
        end
        step(SEQ_RW, STEP_6_3);
        lastAck = 11'h1 << ackIdx(u, isIn);
        chk("ackLines", lastAck, ackLines);
    endtask

    // wait for the peer to take all expected characters, then compare in order
    task automatic drain(input string what, input logic full);
        char_t c, e;
        int    n;
        n = 0;
        while (periph_model_i.got.size() < expQ.size() && n < 400) begin
            @(posedge clock);
            n++;
        end
        chk({what, " count"}, expQ.size(), periph_model_i.got.size());
        while (expQ.size() > 0 && periph_model_i.got.size() > 0) begin
            c = periph_model_i.got.pop_front();
            e = expQ.pop_front();
            if (full) chk(what, e, c);
            else chk(what, e.data, c.data);
        end
        expQ.delete();
        periph_model_i.got.delete();
    endtask

    task automatic external_function_instr(input logic [4:0] code, input int idx);
        @(posedge clock);
        honor <= '0;
        exfUnit <= code;
        exfInstr <= {16'h0700, 3'h2, code};
        step(SEQ_EXF_READ, STEP_1_2);
        step(SEQ_EXF_READ, STEP_1_3);
        step(SEQ_EXF_READ, STEP_3_3);
        expQ.push_back(char_t'{PER_TAPE, exfInstr[7:0]});
        step(SEQ_EXF_READ, STEP_6_3);
        lastAck = 11'h1 << idx;
        chk("exf ackLines", lastAck, ackLines);
    endtask

    task automatic t_eight();
        for (int i = 0; i < 3; i++) rw(PER_PAPER, 1'b0, 1'b0, 2'(i), 24'ha1b2c3);
        drain("eight-bit chars", 1'b1);
        $display("done eight-bit output");
    endtask

    task automatic t_six();
        for (int i = 0; i < 4; i++) rw(PER_TAPE, 1'b0, 1'b1, 2'(i), 24'h5a3c96);
        rw(PER_CONS2, 1'b0, 1'b0, 2'h1, 24'h13579b);
        rw(PER_AUX, 1'b0, 1'b1, 2'h3, 24'h2468ac);
        rw(PER_PUNCH, 1'b0, 1'b0, 2'h2, 24'hfedcb8);
        drain("six-bit and unit chars", 1'b1);
        $display("done six-bit output");
    endtask

    // input requests give an acknowledge and no character
    task automatic t_input();
        rw(PER_CONS1, 1'b1, 1'b0, 2'h0, 24'h0);
        rw(PER_TAPE, 1'b1, 1'b1, 2'h0, 24'h0);
        rw(PER_PAPER, 1'b1, 1'b0, 2'h0, 24'h0);
        rw(PER_AUX, 1'b1, 1'b1, 2'h0, 24'h0);
        repeat (4) @(posedge clock);
        #1;
        chk("no char on input", 0, charValid);
        $display("done input acknowledges");
    endtask

    task automatic t_exf();
        external_function_instr(UNIT_TAPE, ACK_TAPE_OUT);
        external_function_instr(UNIT_AUX_IN, ACK_AUX_IN);
        external_function_instr(UNIT_AUX_OUT, ACK_AUX_OUT);
        external_function_instr(UNIT_PUNCH, ACK_PUNCH_OUT);
        drain("exf chars", 1'b0);
        $display("done external function");
    endtask

    // stalled peer lets the buffer fill, then it drains to empty
    task automatic t_fill();
        stall <= 1'b1;
        for (int i = 0; i < FIFO_DEPTH; i++) rw(PER_PUNCH, 1'b0, 1'b0, 2'h0, 24'(i * 'h10101));
        chk("charSpace full", 0, charSpace);
        stall <= 1'b0;
        drain("buffered chars", 1'b1);
        #1;
        chk("charValid empty", 0, charValid);
        chk("charSpace empty", 1, charSpace);
        $display("done buffer fill");
    endtask

    task automatic t_timebase();
        int n;
        @(posedge clock);
        armSet <= 1'b1;
        intHonored <= 1'b1;
        intWord <= {10'h005, 14'h0abc};
        progCount <= 14'h1234;
        @(posedge clock);
        armSet <= 1'b0;
        n = 0;
        while (intRequest !== 1'b1 && n < 100) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk("tick wait", 1, n >= TICKS - 2 && n <= TICKS + 1);
        step(SEQ_CW_WRITE, STEP_3_3);
        chk("tallyWrite", 1, tallyWrite);
        chk("tallyNext", 10'h004, tallyNext);
        intWord <= {10'h000, 14'h0abc};
        step(SEQ_INT_READ, STEP_1_2);
        chk("armed cleared", 0, armed);
        step(SEQ_INT_READ, STEP_1_3);
        chk("loadProg", 1, loadProg);
        chk("returnAddr", 14'h1234, returnAddr);
        chk("newProgCount", 14'h0abc, newProgCount);
        intHonored <= 1'b0;
        repeat (TICKS + 4) @(posedge clock);
        #1;
        chk("no tick unarmed", 0, intRequest);
        @(posedge clock);
        armSet <= 1'b1;
        armClear <= 1'b1;
        @(posedge clock);
        armSet <= 1'b0;
        armClear <= 1'b0;
        @(posedge clock);
        #1;
        chk("disarm wins", 0, armed);
        $display("done time base");
    endtask

    // watchdog: the full run needs well under 20000 cycles
    initial begin
        #200000;
        numErrors++;
        finish_test();
    end

    initial begin
        seq = '{SEQ_IDLE, STEP_NONE};
        honor = '0;
        ctrlWord = '0;
        {memWord, exfInstr, intWord, exfUnit, progCount} = '0;
        {armSet, armClear, intHonored, stall} = '0;
        lastAck = '0;
        rst_b = 1'b0;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        chk("reset charValid", 0, charValid);
        chk("reset ackLines", 0, ackLines);
        t_eight();
        t_six();
        t_input();
        t_exf();
        t_fill();
        t_timebase();
        finish_test();
    end
endmodule
`default_nettype wire
